// file: hw/ext_bus_port.sv
// External memory bus port with Port 0 nibble modes, handshake and reset sequencing.
`timescale 1ns/10ps
// Contract
// RULE_01: Reset low pulses shorter than four input clocks cause no reset.
// RULE_02: Internal reset latches on fifth low clock, held 18 clocks or longer.
// RULE_03: Fetching starts at 000C, five to ten clocks after reset release.
// RULE_04: Stop-mode recovery leaves watchdog and mode registers unchanged; the bus port reloads Port 0 modes and extended timing on core reset.
// RULE_05: Power-on and watchdog reset drive the reset pin low.
// RULE_06: External reset drivers must be open-drain.
// RULE_07: External reset resets controller and signal processor together.
// RULE_08: Romless select high fetches externally, low uses internal memory.
// RULE_09: Read/write line high on reads, low on writes.
// RULE_10: Address strobe pulses low per cycle; address valid at its rise.
// RULE_11: Data strobe once per transfer; falling edge marks write data valid.
// RULE_12: Memory presents read data before data strobe rises.
// RULE_13: Release floats strobes, read/write and ports 0 and 1 together.
// RULE_14: Port 0 nibbles are configured as general I/O or address.
// RULE_15: Low nibble alone may carry address bits 11 to 8.
// RULE_16: Port 0 handshake uses port 3 bits 2 and 5, direction from upper nibble.
// RULE_17: Software keeps both Port 0 nibbles in the same handshake direction.
// RULE_18: Romless reset sets Port 0 to address 15:8 with extended timing.
// RULE_19: Internal-memory reset sets all Port 0 lines as inputs.
// RULE_20: Output handshake data stands one clock before data-valid falls.
// RULE_21: Output handshake raises data-valid after the peer drops ready.
// RULE_22: Input handshake drops ready on data-valid fall, raises on its rise.
// RULE_23: Port 1 multiplexes low address and data bytes.
module ext_bus_port #(
  parameter int POR_CYCLES = 64
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Reset pin, open drain, and reset sources
  input wire logic reset_pin_in_n,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic por_req,
  input wire logic wdt_req,
  input wire logic smr_req,
  // Reset outputs
  output logic core_reset_n,
  output logic dsp_reset_n,
  output logic full_reset_n,
  // Configuration and software control
  input wire logic romless_select,
  input wire logic bus_release,
  input wire logic p0_cfg_wr,
  input wire logic [1:0] p0_cfg_addr_mode,
  input wire logic p0_cfg_ext_timing,
  input wire logic p0_hs_enable,
  input wire logic [1:0] p0_io_dir,
  input wire logic [7:0] p0_io_out,
  output logic ext_timing,
  output logic fetch_internal,
  // Memory request
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_busy,
  output logic mem_done,
  output logic [7:0] mem_rdata,
  // External bus pins
  output logic address_strobe_n,
  output logic address_strobe_oe,
  output logic data_strobe_n,
  output logic data_strobe_oe,
  output logic read_write_n,
  output logic read_write_oe,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  // Port 0 handshake on port 3 bit 2 (in) and bit 5 (out)
  input wire logic hs_line_in,
  output logic hs_line_out,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  import bus_port_pkg::*;
  typedef struct packed {
    bus_st_t bus;
    hs_st_t hs;
    logic [3:0] cnt;
    logic [1:0] hs_cnt;
    logic [1:0] addr_mode;
    logic ext_tim;
    logic romless;
    logic release_bus;
    logic fetch_pend;
    logic fetch_int;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] hs_data;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic as_n;
    logic ds_n;
    logic rw_n;
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p1_out;
    logic [7:0] p1_oe;
    logic hs_out;
    logic tx_rdy;
    logic rx_vld;
    logic [7:0] rx_dat;
  } port_st_t;
  localparam port_st_t PORT_RST = '{bus: B_IDLE, hs: H_IDLE, rw_n: 1'b1, as_n: 1'b1,
    ds_n: 1'b1, hs_out: 1'b1, default: '0};
  port_st_t s_q, s_d;
  rst_ctl_if rc ();
  logic hs_dir_out;
  logic [3:0] ds_len;

  assign rc.pin_in_n = reset_pin_in_n;
  assign rc.por_req = por_req;
  assign rc.wdt_req = wdt_req;
  assign rc.smr_req = smr_req;

  reset_seq #(.POR_CYCLES(POR_CYCLES)) u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rc(rc)
  );

  // Handshake direction is steered by the upper nibble only.
  assign hs_dir_out = p0_io_dir[1];
  assign ds_len = 4'(s_q.wr ? DS_WRITE_CYCLES : DS_READ_CYCLES) +
    (s_q.ext_tim ? 4'(EXT_TIMING_EXTRA) : 4'h0);

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.fetch_int = 1'b0;
    s_d.tx_rdy = 1'b0;
    s_d.rx_vld = 1'b0;
    // RULE_14: software nibble configuration.
    if (p0_cfg_wr) begin
      s_d.addr_mode = p0_cfg_addr_mode;
      s_d.ext_tim = p0_cfg_ext_timing;
    end
    // RULE_08: external or internal start of fetch.
    if (rc.fetch_go) begin
      s_d.fetch_pend = s_q.romless;
      s_d.fetch_int = !s_q.romless;
    end
    unique case (s_q.bus)
      B_IDLE: begin
        // Release is only taken between transfers so a cycle never floats halfway.
        s_d.release_bus = bus_release;
        if (!bus_release && (s_q.fetch_pend || mem_req)) begin
          s_d.wr = !s_q.fetch_pend && mem_write;
          // RULE_03: first fetch address.
          s_d.addr = s_q.fetch_pend ? START_ADDR : mem_addr;
          s_d.wdata = mem_wdata;
          // A fetch start that lands on a memory take stays pending.
          s_d.fetch_pend = s_d.fetch_pend && !s_q.fetch_pend;
          s_d.busy = 1'b1;
          s_d.as_n = 1'b0;
          s_d.cnt = 4'(AS_LOW_CYCLES - 1);
          s_d.bus = B_ADDR;
        end
      end
      B_ADDR: begin
        if (s_q.cnt == 4'h0) begin
          // RULE_10: address held over the strobe rise.
          s_d.as_n = 1'b1;
          s_d.bus = B_GAP;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      B_GAP: begin
        // RULE_11: one data strobe per transfer.
        s_d.ds_n = 1'b0;
        s_d.cnt = ds_len - 4'h1;
        s_d.bus = B_STRB;
      end
      B_STRB: begin
        if (s_q.cnt == 4'h0) begin
          // RULE_12: read data sampled before the strobe rises.
          if (!s_q.wr) begin
            s_d.rdata = port1_in;
          end
          s_d.ds_n = 1'b1;
          s_d.bus = B_END;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      B_END: begin
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        s_d.bus = B_IDLE;
      end
      default: s_d.bus = B_IDLE;
    endcase
    // RULE_09: read/write level follows the transfer.
    s_d.rw_n = !(s_d.wr && s_d.bus != B_IDLE);
    // RULE_23: low address then data on Port 1.
    s_d.p1_out = (s_d.bus == B_STRB || s_d.bus == B_END) ? s_d.wdata : s_d.addr[7:0];
    s_d.p1_oe = {8{s_d.bus != B_IDLE && !(s_d.bus inside {B_STRB, B_END} && !s_d.wr)}};
    // RULE_16: handshake on port 3 bits 2 and 5.
    if (!p0_hs_enable || s_q.addr_mode[1]) begin
      s_d.hs = H_IDLE;
      s_d.hs_out = 1'b1;
    end else begin
      unique case (s_q.hs)
        H_IDLE: begin
          s_d.hs_out = 1'b1;
          if (hs_dir_out && tx_valid) begin
            s_d.hs_data = tx_data;
            s_d.hs_cnt = 2'(HS_SETUP_CYCLES - 1);
            s_d.hs = H_SETUP;
          end else if (!hs_dir_out && !hs_line_in) begin
            // RULE_22: ready drops after data-valid falls.
            s_d.rx_dat = port0_in;
            s_d.hs_out = 1'b0;
            s_d.hs = H_WAIT;
          end
        end
        H_SETUP: begin
          // RULE_20: data stands before data-valid falls.
          if (s_q.hs_cnt == 2'h0) begin
            s_d.hs_out = 1'b0;
            s_d.hs = H_WAIT;
          end else begin
            s_d.hs_cnt = s_q.hs_cnt - 2'h1;
          end
        end
        H_WAIT: begin
          if (hs_dir_out && !hs_line_in) begin
            // RULE_21: data-valid returns high.
            s_d.hs_out = 1'b1;
            s_d.tx_rdy = 1'b1;
            s_d.hs = H_DONE;
          end else if (!hs_dir_out && hs_line_in) begin
            // RULE_22: ready rises after data-valid rises.
            s_d.hs_out = 1'b1;
            s_d.rx_vld = 1'b1;
            s_d.hs = H_IDLE;
          end
        end
        H_DONE: begin
          if (hs_line_in) begin
            s_d.hs = H_IDLE;
          end
        end
        default: s_d.hs = H_IDLE;
      endcase
    end
    // RULE_15: each nibble is address or general I/O on its own.
    for (int n = 0; n < 2; n++) begin
      if (s_d.addr_mode[n]) begin
        s_d.p0_out[n*4 +: 4] = s_d.addr[8 + n*4 +: 4];
        s_d.p0_oe[n*4 +: 4] = 4'hf;
      end else begin
        s_d.p0_out[n*4 +: 4] = (s_d.hs != H_IDLE && hs_dir_out) ? s_d.hs_data[n*4 +: 4] : p0_io_out[n*4 +: 4];
        s_d.p0_oe[n*4 +: 4] = {4{p0_io_dir[n]}};
      end
    end
    // RULE_13: release floats every bus output.
    if (s_d.release_bus) begin
      s_d.p0_oe = 8'h0;
      s_d.p1_oe = 8'h0;
    end
    if (!rc.core_rst_n) begin
      s_d = PORT_RST;
      // RULE_18: romless reset selects address and extended timing.
      // RULE_19: internal-memory reset leaves Port 0 as inputs.
      s_d.romless = romless_select;
      s_d.addr_mode = romless_select ? P0_MODE_ROMLESS : P0_MODE_ROM;
      s_d.ext_tim = romless_select;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= PORT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = rc.pin_drive;
  assign core_reset_n = rc.core_rst_n;
  assign dsp_reset_n = rc.dsp_rst_n;
  assign full_reset_n = rc.full_rst_n;
  assign ext_timing = s_q.ext_tim;
  assign fetch_internal = s_q.fetch_int;
  assign mem_busy = s_q.busy;
  assign mem_done = s_q.done;
  assign mem_rdata = s_q.rdata;
  assign address_strobe_n = s_q.as_n;
  assign data_strobe_n = s_q.ds_n;
  assign read_write_n = s_q.rw_n;
  assign address_strobe_oe = !s_q.release_bus;
  assign data_strobe_oe = !s_q.release_bus;
  assign read_write_oe = !s_q.release_bus;
  assign port0_out = s_q.p0_out;
  assign port0_oe = s_q.p0_oe;
  assign port1_out = s_q.p1_out;
  assign port1_oe = s_q.p1_oe;
  assign hs_line_out = s_q.hs_out;
  assign tx_ready = s_q.tx_rdy;
  assign rx_valid = s_q.rx_vld;
  assign rx_data = s_q.rx_dat;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !core_reset_n);
  a_as_single_pulse: assert property ($fell(address_strobe_n) |=> $rose(address_strobe_n)) // RULE_10
    else $error("address strobe low for more than one cycle");
  a_addr_at_as_rise: assert property ($rose(address_strobe_n) |-> $stable(port1_out) && port1_oe == 8'hff) // RULE_10
    else $error("address not stable at address strobe rise");
  a_ds_follows_as: assert property ($rose(address_strobe_n) |-> ##1 $fell(data_strobe_n)) // RULE_11
    else $error("data strobe missing after address strobe");
  a_write_data_valid: assert property ($fell(data_strobe_n) && !read_write_n |-> port1_out == s_q.wdata) // RULE_11
    else $error("write data not valid at data strobe fall");
  a_rw_level: assert property (!data_strobe_n |-> read_write_n == !s_q.wr) // RULE_09
    else $error("read/write level wrong during data strobe");
  a_release_float: assert property (s_q.release_bus |-> port0_oe == 8'h0 && port1_oe == 8'h0) // RULE_13
    else $error("bus driven while released");
  a_hs_setup: assert property ($fell(hs_line_out) && hs_dir_out |-> $stable(port0_out)) // RULE_20
    else $error("handshake data changed as data-valid fell");
  a_hs_dav_rise: assert property (s_q.hs == H_WAIT && hs_dir_out && !hs_line_in && p0_hs_enable
    && !s_q.addr_mode[1] |=> hs_line_out && tx_ready) // RULE_21
    else $error("data-valid not raised after peer ready fell");
  a_hs_in_ready: assert property (s_q.hs == H_IDLE && !hs_dir_out && !hs_line_in && p0_hs_enable
    && !s_q.addr_mode[1] |=> !hs_line_out) // RULE_22
    else $error("ready not dropped after data-valid fell");
  c_ext_write: cover property ($fell(data_strobe_n) && !read_write_n);
  c_ext_read: cover property (mem_done && read_write_n);
  c_hs_done: cover property (tx_ready || rx_valid);
endmodule

// file: hw/bus_port_pkg.sv
// Shared constants for the reset sequencer and external bus port.
package bus_port_pkg;
  // Clock and base period; the input clock period equals the ref_clk period.
  localparam int CLK_PERIOD_NS = 4;
  localparam int INPUT_CLOCK_PERIOD_NS = 4;
  // Reset filter, stretch and fetch delay, counted in input clock periods.
  localparam int FILTER_LOW_CYCLES = 4;
  localparam int STRETCH_CYCLES = 18;
  localparam int FETCH_DELAY_CYCLES = 6;
  localparam int CNT_W = 5;
  localparam logic [15:0] START_ADDR = 16'h000c;
  // External bus strobe lengths and the extended timing addition.
  localparam int AS_LOW_CYCLES = 1;
  localparam int DS_READ_CYCLES = 3;
  localparam int DS_WRITE_CYCLES = 2;
  localparam int EXT_TIMING_EXTRA = 2;
  // Handshake data setup ahead of the strobe, in input clock periods.
  localparam int HS_SETUP_TPC = 1;
  localparam int HS_SETUP_CYCLES =
    (HS_SETUP_TPC * INPUT_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Port 0 nibble modes after reset: bit 0 low nibble, bit 1 high nibble, 1 means address.
  localparam logic [1:0] P0_MODE_ROMLESS = 2'h3;
  localparam logic [1:0] P0_MODE_ROM = 2'h0;
  typedef enum logic [2:0] {
    B_IDLE = 3'h0,
    B_ADDR = 3'h1,
    B_GAP = 3'h3,
    B_STRB = 3'h2,
    B_END = 3'h6
  } bus_st_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SETUP = 2'h1,
    H_WAIT = 2'h3,
    H_DONE = 2'h2
  } hs_st_t;
endpackage

// file: hw/rst_ctl_if.sv
// Signals between the reset sequencer and the bus port.
`timescale 1ns/10ps
interface rst_ctl_if;
  logic pin_in_n;
  logic por_req;
  logic wdt_req;
  logic smr_req;
  logic core_rst_n;
  logic dsp_rst_n;
  logic full_rst_n;
  logic fetch_go;
  logic pin_drive;
  modport seq (input pin_in_n, por_req, wdt_req, smr_req,
               output core_rst_n, dsp_rst_n, full_rst_n, fetch_go, pin_drive);
  modport user (output pin_in_n, por_req, wdt_req, smr_req,
                input core_rst_n, dsp_rst_n, full_rst_n, fetch_go, pin_drive);
endinterface

// file: hw/reset_seq.sv
// Reset filter, stretcher, power-on pin drive and fetch start timing.
`timescale 1ns/10ps
module reset_seq #(
  parameter int POR_CYCLES = 64
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Reset control carrier
  rst_ctl_if.seq rc
);
  import bus_port_pkg::*;
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  typedef struct packed {
    logic [2:0] low;
    logic latched;
    logic ext;
    logic [CNT_W-1:0] hold;
    logic [POR_W-1:0] por_cnt;
    logic [3:0] fetch_cnt;
    logic fetch_go;
    logic pin_drive;
    logic core_rst_n;
    logic dsp_rst_n;
    logic full_rst_n;
  } seq_st_t;
  localparam seq_st_t SEQ_RST = '{low: 3'h0, latched: 1'b1, ext: 1'b1, hold: '0,
    por_cnt: POR_W'(POR_CYCLES - 1), fetch_cnt: 4'h0, fetch_go: 1'b0, pin_drive: 1'b1,
    core_rst_n: 1'b0, dsp_rst_n: 1'b0, full_rst_n: 1'b0};
  seq_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.fetch_go = 1'b0;
    if (s_q.fetch_cnt != 4'h0) begin
      s_d.fetch_cnt = s_q.fetch_cnt - 4'h1;
      // RULE_03: fetch start delay.
      s_d.fetch_go = (s_q.fetch_cnt == 4'h1);
    end
    // RULE_01: count consecutive low samples.
    if (s_q.pin_drive || rc.pin_in_n) begin
      s_d.low = 3'h0;
    end else if (s_q.low != 3'(FILTER_LOW_CYCLES)) begin
      s_d.low = s_q.low + 3'h1;
    end
    if (rc.por_req || rc.wdt_req) begin
      // RULE_05: drive pin low.
      s_d.pin_drive = 1'b1;
      s_d.por_cnt = POR_W'(POR_CYCLES - 1);
      s_d.latched = 1'b1;
      s_d.ext = 1'b1;
    end else if (s_q.pin_drive) begin
      if (s_q.por_cnt == '0) begin
        s_d.pin_drive = 1'b0;
      end else begin
        s_d.por_cnt = s_q.por_cnt - POR_W'(1);
      end
    end else if (!s_q.latched && !rc.pin_in_n && s_q.low == 3'(FILTER_LOW_CYCLES)) begin
      // RULE_02: latch on the fifth low clock.
      s_d.latched = 1'b1;
      s_d.ext = 1'b1;
    end else if (!s_q.latched && rc.smr_req) begin
      s_d.latched = 1'b1;
      s_d.ext = 1'b0;
    end else if (s_q.latched) begin
      // RULE_02: hold for the longer of both.
      if (s_q.hold != CNT_W'(STRETCH_CYCLES)) begin
        s_d.hold = s_q.hold + CNT_W'(1);
      end else if (rc.pin_in_n) begin
        s_d.latched = 1'b0;
        s_d.fetch_cnt = 4'(FETCH_DELAY_CYCLES);
      end
    end
    if (s_d.latched && !s_q.latched || rc.por_req || rc.wdt_req) begin
      s_d.hold = '0;
      s_d.fetch_cnt = 4'h0;
    end
    // RULE_07: core and signal processor reset together.
    s_d.core_rst_n = !s_d.latched;
    s_d.dsp_rst_n = !s_d.latched;
    // RULE_04: stop-mode recovery spares the full reset.
    s_d.full_rst_n = !(s_d.latched && s_d.ext);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= SEQ_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rc.core_rst_n = s_q.core_rst_n;
  assign rc.dsp_rst_n = s_q.dsp_rst_n;
  assign rc.full_rst_n = s_q.full_rst_n;
  assign rc.fetch_go = s_q.fetch_go;
  assign rc.pin_drive = s_q.pin_drive;

  // Helper length counter of the internal reset, read only by the checks below.
  logic [7:0] rst_len_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || s_q.core_rst_n) begin
      rst_len_q <= 8'h0;
    end else if (rst_len_q != 8'hff) begin
      rst_len_q <= rst_len_q + 8'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_filter_five_lows: assert property ($fell(s_q.core_rst_n) && s_q.ext && !s_q.pin_drive
    |-> !$past(rc.pin_in_n, 1) && !$past(rc.pin_in_n, 2) && !$past(rc.pin_in_n, 3)
    && !$past(rc.pin_in_n, 4) && !$past(rc.pin_in_n, 5)) // RULE_01
    else $error("internal reset latched without five low samples");
  a_stretch_min: assert property ($rose(s_q.core_rst_n) |-> $past(rst_len_q) >= 8'(STRETCH_CYCLES)) // RULE_02
    else $error("internal reset shorter than the stretch time");
  a_fetch_window: assert property ($rose(s_q.core_rst_n) |-> ##[5:10] s_q.fetch_go) // RULE_03
    else $error("fetch start outside its window");
  a_smr_keeps_regs: assert property (!s_q.core_rst_n && !s_q.ext |-> s_q.full_rst_n) // RULE_04
    else $error("stop-mode recovery cleared preserved registers");
  a_por_pin_drive: assert property ($rose(s_q.pin_drive) |-> s_q.pin_drive[*8] ##0 !s_q.core_rst_n) // RULE_05
    else $error("reset pin drive ended early");
  a_dsp_with_core: assert property (s_q.dsp_rst_n == s_q.core_rst_n) // RULE_07
    else $error("signal processor reset differs from core reset");
  c_ext_reset: cover property ($fell(s_q.core_rst_n) && s_q.ext && !s_q.pin_drive);
  c_smr_reset: cover property ($fell(s_q.core_rst_n) && !s_q.ext);
endmodule

// file: tb/ext_peer_model.sv
// External memory and Port 0 handshake peer model.
`timescale 1ns/10ps
module ext_peer_model (
  // Clock
  input wire logic clk,
  // Memory bus
  input wire logic as_n,
  input wire logic ds_n,
  input wire logic rw_n,
  input wire logic [7:0] p0,
  input wire logic [7:0] p1o,
  output logic [7:0] p1i,
  output logic [15:0] last_addr,
  // Handshake peer
  input wire logic dav_n,
  output logic rdy,
  output logic [7:0] got
);
  logic [7:0] mem [0:4095];
  logic [7:0] p0_prev;
  logic dav_prev;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5a;
    p1i = 8'h00;
    rdy = 1'b1;
    got = 8'h00;
    last_addr = 16'h0000;
    p0_prev = 8'h00;
    dav_prev = 1'b1;
  end
  always @(posedge clk) begin
    p0_prev <= p0;
    dav_prev <= dav_n;
    if (!as_n) last_addr <= {p0, p1o};
    // data inside strobe
    // Outside the strobe the bus toggles, but the byte still stands for one clock after the strobe rises.
    if (!ds_n && rw_n) p1i <= mem[last_addr[11:0]];
    else p1i <= ~p1i;
    if (!ds_n && !rw_n) mem[last_addr[11:0]] <= p1o;
    // The byte taken is the one that stood before the strobe fell.
    if (!dav_n && dav_prev) begin
      got <= p0_prev;
      rdy <= 1'b0;
    end else if (dav_n) rdy <= 1'b1;
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the reset sequencer and external bus port.
`timescale 1ns/10ps
module tb_top;
  import bus_port_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, tb_pull = 1'b0, tb_dav_n = 1'b1;
  logic por_req = 1'b0, wdt_req = 1'b0, smr_req = 1'b0, romless_select = 1'b0, bus_release = 1'b0;
  logic p0_cfg_wr = 1'b0, p0_cfg_ext_timing = 1'b0, p0_hs_enable = 1'b0, mem_req = 1'b0, mem_write = 1'b0;
  logic tx_valid = 1'b0;
  logic [1:0] p0_cfg_addr_mode = 2'h0, p0_io_dir = 2'h0;
  logic [7:0] p0_io_out = 8'h00, mem_wdata = 8'h00, tx_data = 8'h00, p0_drive = 8'h00;
  logic [15:0] mem_addr = 16'h0000, bus_addr;
  logic reset_pin_in_n, reset_pin_out, reset_pin_oe, core_reset_n, dsp_reset_n, full_reset_n;
  logic ext_timing, fetch_internal, mem_busy, mem_done, address_strobe_n, address_strobe_oe;
  logic data_strobe_n, data_strobe_oe, read_write_n, read_write_oe, hs_line_in, hs_line_out;
  logic tx_ready, rx_valid, peer_rdy, rw_at_ds;
  logic [7:0] mem_rdata, port0_in, port0_out, port0_oe, port1_in, port1_out, port1_oe, rx_data, peer_got, oe_at_as;
  int bad_count = 0, n_tests = 0, cyc = 0, ds_falls = 0, ds_low = 0, core_lo = 0, full_lo = 0, pin_lo = 0, split = 0;
  assign reset_pin_in_n = !(reset_pin_oe || tb_pull);
  assign port0_in = (port0_out & port0_oe) | (p0_drive & ~port0_oe);
  assign hs_line_in = p0_io_dir[1] ? peer_rdy : tb_dav_n;
  ext_bus_port #(.POR_CYCLES(8)) dut (.ref_clk, .rst_n, .reset_pin_in_n, .reset_pin_out, .reset_pin_oe, .por_req,
    .wdt_req, .smr_req, .core_reset_n, .dsp_reset_n, .full_reset_n, .romless_select, .bus_release, .p0_cfg_wr,
    .p0_cfg_addr_mode, .p0_cfg_ext_timing, .p0_hs_enable, .p0_io_dir, .p0_io_out, .ext_timing, .fetch_internal,
    .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_busy, .mem_done, .mem_rdata, .address_strobe_n,
    .address_strobe_oe, .data_strobe_n, .data_strobe_oe, .read_write_n, .read_write_oe, .port0_in, .port0_out,
    .port0_oe, .port1_in, .port1_out, .port1_oe, .hs_line_in, .hs_line_out, .tx_valid, .tx_data, .tx_ready,
    .rx_valid, .rx_data);
  ext_peer_model peer (.clk(ref_clk), .as_n(address_strobe_n), .ds_n(data_strobe_n), .rw_n(read_write_n),
    .p0(port0_out), .p1o(port1_out), .p1i(port1_in), .last_addr(bus_addr), .dav_n(hs_line_out), .rdy(peer_rdy),
    .got(peer_got));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (data_strobe_n === 1'b0) ds_low++;
    if (core_reset_n === 1'b0) core_lo++;
    if (full_reset_n === 1'b0) full_lo++;
    if (reset_pin_oe === 1'b1) pin_lo++;
    if (core_reset_n !== dsp_reset_n) split++;
    if (address_strobe_n === 1'b0) oe_at_as = port0_oe;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  always @(negedge data_strobe_n) begin
    ds_falls++;
    rw_at_ds = read_write_n;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  // Waits are bounded; the caller judges the level reached.
  task automatic wait_lv(ref logic s, input logic v);
    for (int i = 0; i < 100 && s !== v; i++) @(posedge ref_clk);
  endtask
  task automatic do_reset(input logic rl);
    int n, f;
    f = ds_falls;
    @(posedge ref_clk);
    romless_select <= rl;
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check(32'({reset_pin_oe, reset_pin_out}), 32'h2, "pin drive");
    wait_lv(core_reset_n, 1'b1);
    check(32'(dsp_reset_n), 32'h1, "dsp release");
    if (rl) begin
      ds_low = 0;
      wait_lv(mem_done, 1'b1);
      check(32'(bus_addr), 32'(START_ADDR), "fetch addr");
      check(32'({ext_timing, oe_at_as}), 32'h1ff, "romless port0");
      check(32'(ds_low), 32'(DS_READ_CYCLES + EXT_TIMING_EXTRA), "ext timing");
      check(32'(mem_rdata), 32'h56, "fetch data");
    end else begin
      n = 0;
      while (fetch_internal !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        n++;
      end
      check(32'(n >= 5 && n <= 10), 32'h1, "fetch delay");
      check(32'({ext_timing, port0_oe}), 32'h0, "rom port0");
      check(32'(ds_falls - f), 32'h0, "internal fetch");
    end
  endtask
  task automatic pulse(input int n);
    @(posedge ref_clk);
    core_lo = 0;
    tb_pull <= 1'b1;
    repeat (n) @(posedge ref_clk);
    tb_pull <= 1'b0;
    repeat (60) @(posedge ref_clk);
  endtask
  task automatic t_source(input int k);
    @(posedge ref_clk);
    full_lo = 0;
    pin_lo = 0;
    core_lo = 0;
    por_req <= (k == 0);
    wdt_req <= (k == 1);
    smr_req <= (k == 2);
    @(posedge ref_clk);
    {por_req, wdt_req, smr_req} <= 3'h0;
    repeat (80) @(posedge ref_clk);
    check(32'(core_lo != 0), 32'h1, "core reset");
    check(32'(full_lo != 0), 32'(k != 2), "preserve");
    check(32'(pin_lo >= 8), 32'(k != 2), "source pin");
  endtask
  task automatic mem_xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int f;
    @(posedge ref_clk);
    f = ds_falls;
    ds_low = 0;
    mem_req <= 1'b1;
    mem_write <= wr;
    mem_addr <= a;
    mem_wdata <= d;
    wait_lv(mem_busy, 1'b1);
    mem_req <= 1'b0;
    wait_lv(mem_done, 1'b1);
    check(32'(bus_addr[11:0]), 32'(a[11:0]), "bus addr");
    check(32'(oe_at_as), 32'h0f, "low nibble addr");
    check(32'(ds_falls - f), 32'h1, "one data strobe");
    check(32'(rw_at_ds), 32'(!wr), "rw level");
    check(32'(ds_low), wr ? 32'(DS_WRITE_CYCLES) : 32'(DS_READ_CYCLES), "ds len");
    if (!wr) check(32'(mem_rdata), 32'(d), "read data");
  endtask
  task automatic t_hs(input logic [7:0] d);
    @(posedge ref_clk);
    p0_cfg_addr_mode <= 2'h0;
    p0_cfg_wr <= 1'b1;
    @(posedge ref_clk);
    p0_cfg_wr <= 1'b0;
    p0_hs_enable <= 1'b1;
    p0_io_dir <= 2'h3;
    tx_data <= d;
    tx_valid <= 1'b1;
    wait_lv(tx_ready, 1'b1);
    tx_valid <= 1'b0;
    check(32'(peer_got), 32'(d), "hs out data");
    repeat (3) @(posedge ref_clk);
    check(32'(hs_line_out), 32'h1, "hs out idle");
    p0_io_dir <= 2'h0;
    p0_drive <= ~d;
    repeat (3) @(posedge ref_clk);
    tb_dav_n <= 1'b0;
    wait_lv(hs_line_out, 1'b0);
    check(32'(hs_line_out), 32'h0, "ready drop");
    tb_dav_n <= 1'b1;
    wait_lv(rx_valid, 1'b1);
    check(32'({hs_line_out, rx_data}), 32'({1'b1, ~d}), "hs in data");
    p0_hs_enable <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    do_reset(1'b0);
    pulse(4);
    check(32'(core_lo), 32'h0, "short pulse");
    pulse(5);
    check(32'(core_lo >= STRETCH_CYCLES), 32'h1, "stretch");
    pulse(40);
    check(32'(core_lo >= 35), 32'h1, "long pulse");
    for (int k = 0; k < 3; k++) t_source(k);
    check(32'(split), 32'h0, "cores together");
    @(posedge ref_clk);
    p0_cfg_addr_mode <= 2'h1;
    p0_cfg_wr <= 1'b1;
    @(posedge ref_clk);
    p0_cfg_wr <= 1'b0;
    mem_xfer(1'b1, 16'h0a37, 8'hc4);
    mem_xfer(1'b0, 16'h0a37, 8'hc4);
    mem_xfer(1'b0, 16'h0123, 8'h79);
    @(posedge ref_clk);
    bus_release <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check(32'({address_strobe_oe, data_strobe_oe, read_write_oe, port0_oe, port1_oe}), 32'h0, "float");
    bus_release <= 1'b0;
    t_hs(8'ha5);
    tally_and_finish();
  end
endmodule
